// ==== rtl/alignment_window_align_map.vh ====
// Purpose: Register indices, field positions and reset values of the ALIGNMENT_WINDOW alignment bank
// Assumes: Byte address on the bus is four times the register index
// Notes: Definitions only
`ifndef ALIGNMENT_WINDOW_ALIGN_MAP_VH
`define ALIGNMENT_WINDOW_ALIGN_MAP_VH

// Register indices
`define IDX_ALIGN_SEL 10'h1e8
`define IDX_FRAME_SHIFT 10'h1e9
`define IDX_ALIGN_WIN 10'h1ea
`define IDX_LANE_A 10'h1eb
`define IDX_LANE_B 10'h1ec
`define IDX_EMPHASIS 10'h1ef
`define IDX_STBY_BIAS 10'h250
`define IDX_SYNTH_EN 10'h2a0
`define IDX_DIV_LOW 10'h2a1
`define IDX_DIV_HIGH 10'h2a2
`define IDX_REF_DIV 10'h2bb

// Reset values
`define RST_ALIGN_SEL 8'h00
`define RST_FRAME_SHIFT 8'h00
`define RST_ALIGN_WIN 8'h00
`define RST_LANE_A 8'h1c
`define RST_LANE_B 8'h00
`define RST_EMPHASIS 8'h00
`define RST_STBY_BIAS 8'hff
`define RST_SYNTH_EN 8'h00
`define RST_DIV_LOW 8'h80
`define RST_DIV_HIGH 8'h00
`define RST_REF_DIV 8'hb9

// Fields of pulse_alignment_select
`define BIT_ALIGN_EVERY 0
`define BIT_ALIGN_ONCE 1
`define BIT_ALIGN_SECOND 2
`define BIT_NCO_EVERY 4
`define BIT_NCO_ONCE 5
`define BIT_NCO_SECOND 6

// Other fields
`define BIT_LANE_POL 7
`define BIT_REF_SAMPLE_SEL 3
`define MSB_FRAME_SHIFT 4
`define MSB_EARLY_WIN 7
`define LSB_EARLY_WIN 4
`define MSB_LATE_WIN 3
`define MSB_DIV_HIGH 2

`endif

// ==== rtl/alignment_window_alignment_control_bank.v ====
// Purpose: APB register bank steering ALIGNMENT_WINDOW divider alignment and NCO phase reset
// Assumes: pclk is the converter clock domain; alignment_window_pin is asynchronous; ref_tick is a
//   one-cycle enable on pclk from the synthesizer reference divider
// Notes: APB answers with one wait-free access phase; prdata and pslverr are registered
//
// Summary of operation
// RULE1: While align_every_pulse is set every accepted ALIGNMENT_WINDOW pulse realigns the dividers.
// RULE2: Setting align_once realigns on the align_once pulse only, then the bit clears itself.
// RULE3: With align_on_second_pulse and align_once set, the second pulse aligns, then align_once clears itself.
// RULE4: nco_reset_every with align_every_pulse resets the NCO phases on each realigning pulse.
// RULE5: nco_reset_once with align_once resets the NCO on the next aligning pulse, then clears.
// RULE6: nco_reset_on_second with nco_reset_once and second-pulse mode resets on the second.
// RULE7: The internal LMFC lags ALIGNMENT_WINDOW by the 5-bit offset in frame periods.
// RULE8: Alignment is skipped when ALIGNMENT_WINDOW is early by no more than early_window (2 clocks each).
// RULE9: Alignment is skipped when ALIGNMENT_WINDOW is late by no more than late_window (2 clocks each).
// RULE10: Bit 7 of lane_phy_control_a inverts the serializer polarity when 1.
// RULE11: The divider value is 11 bits; its low byte resets to 0x80.
// RULE12: synth_block_enables holds eight independent enables, all cleared at reset.
// RULE13: Software should write 0x95 to the standby bias register, which resets to 0xff.
// RULE14: The upper three divider bits sit in bits 2:0 of the following register.
// RULE15: ref_sample_clock_select picks the reference tick at 0 or half converter rate at 1.
// RULE16: With no alignment-select bit active ALIGNMENT_WINDOW neither realigns nor resets the NCO.
`timescale 1ns/1ps
`include "alignment_window_align_map.vh"

module alignment_window_alignment_control_bank #(
  parameter FRAME_LEN = 4,
  parameter LMFC_FRAMES = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire alignment_window_pin,
  input wire ref_tick,
  output reg divider_align,
  output reg nco_reset,
  output reg lmfc_pulse,
  output wire lane_polarity_invert,
  output wire external_clock_on,
  output wire converter_clock_on,
  output wire synthesizer_on,
  output wire oscillator_bias_on,
  output wire level_control_on,
  output wire oscillator_on,
  output wire calibration_override_on,
  output wire override_on,
  output wire [10:0] synth_int_n,
  output wire [7:0] standby_bias_code,
  output wire ref_sample_clock_select
);

  localparam [31:0] FRAME_FULL = FRAME_LEN;
  localparam [31:0] PERIOD_FULL = FRAME_LEN * LMFC_FRAMES;
  localparam [11:0] FRAME_W = FRAME_FULL[11:0];
  localparam [11:0] PERIOD_W = PERIOD_FULL[11:0];

  reg [7:0] align_sel_q;
  reg [7:0] frame_shift_q;
  reg [7:0] align_win_q;
  reg [7:0] lane_a_q;
  reg [7:0] lane_b_q;
  reg [7:0] emphasis_q;
  reg [7:0] stby_bias_q;
  reg [7:0] synth_en_q;
  reg [7:0] div_low_q;
  reg [7:0] div_high_q;
  reg [7:0] ref_div_q;
  reg [7:0] rd_value;
  reg sys_meta_q;
  reg sys_sync_q;
  reg sys_samp_q;
  reg half_q;
  reg seen_first_q;
  reg [11:0] phase_q;

  // Index decode shared by the read path, write path and error answer
  function [3:0] reg_slot;
    input [9:0] idx;
    begin
      case (idx)
        `IDX_ALIGN_SEL: reg_slot = 4'h1;
        `IDX_FRAME_SHIFT: reg_slot = 4'h2;
        `IDX_ALIGN_WIN: reg_slot = 4'h3;
        `IDX_LANE_A: reg_slot = 4'h4;
        `IDX_LANE_B: reg_slot = 4'h5;
        `IDX_EMPHASIS: reg_slot = 4'h6;
        `IDX_STBY_BIAS: reg_slot = 4'h7;
        `IDX_SYNTH_EN: reg_slot = 4'h8;
        `IDX_DIV_LOW: reg_slot = 4'h9;
        `IDX_DIV_HIGH: reg_slot = 4'ha;
        `IDX_REF_DIV: reg_slot = 4'hb;
        default: reg_slot = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] slot = reg_slot(paddr[11:2]);
  wire word_ok = (paddr[1:0] == 2'b00) && (slot != 4'h0);
  wire setup_ph = psel & ~penable;
  wire wr_done = psel & penable & pready & pwrite & ~pslverr;
  wire wr_sel = wr_done && (slot == 4'h1);

  always @* begin
    case (slot)
      4'h1: rd_value = align_sel_q;
      4'h2: rd_value = frame_shift_q;
      4'h3: rd_value = align_win_q;
      4'h4: rd_value = lane_a_q;
      4'h5: rd_value = lane_b_q;
      4'h6: rd_value = emphasis_q;
      4'h7: rd_value = stby_bias_q;
      4'h8: rd_value = synth_en_q;
      4'h9: rd_value = div_low_q;
      4'ha: rd_value = div_high_q;
      4'hb: rd_value = ref_div_q;
      default: rd_value = 8'h00;
    endcase
  end

  // Answer is prepared in the setup cycle so the access phase completes at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= ~word_ok;
      prdata <= (word_ok && !pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ALIGNMENT_WINDOW capture: two flops from the pin, then sampled on the chosen tick
  wire half_tick = half_q;
  wire samp_tick = ref_div_q[`BIT_REF_SAMPLE_SEL] ? half_tick : ref_tick; // [RULE15]
  wire sys_rise = samp_tick & sys_sync_q & ~sys_samp_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_meta_q <= 1'b0;
      sys_sync_q <= 1'b0;
      sys_samp_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      sys_meta_q <= alignment_window_pin;
      sys_sync_q <= sys_meta_q;
      half_q <= ~half_q;
      if (samp_tick) begin
        sys_samp_q <= sys_sync_q;
      end
    end
  end

  // Window check against the expected position, which is phase zero
  wire [11:0] early_w = {8'h00, align_win_q[`MSB_EARLY_WIN:`LSB_EARLY_WIN]};
  wire [11:0] late_w = {8'h00, align_win_q[`MSB_LATE_WIN:0]};
  wire late_ok = (phase_q <= late_w); // [RULE9]
  wire early_ok = (phase_q != 12'h000) && (phase_q >= PERIOD_W - early_w); // [RULE8]
  wire in_window = late_ok | early_ok;

  wire mode_every = align_sel_q[`BIT_ALIGN_EVERY];
  wire mode_once = align_sel_q[`BIT_ALIGN_ONCE];
  wire mode_second = align_sel_q[`BIT_ALIGN_SECOND];
  wire once_due = mode_once & (~mode_second | seen_first_q); // [RULE2] [RULE3]
  wire pulse_used = sys_rise & (mode_every | once_due); // [RULE1] [RULE16]
  wire realign = pulse_used & ~in_window;
  wire nco_every = mode_every & align_sel_q[`BIT_NCO_EVERY]; // [RULE4]
  // Second-pulse mode needs the second-pulse NCO bit as well
  wire nco_once = once_due & align_sel_q[`BIT_NCO_ONCE]
                  & (~mode_second | align_sel_q[`BIT_NCO_SECOND]); // [RULE5] [RULE6]
  wire nco_hit = realign & (nco_every | nco_once);
  wire once_taken = sys_rise & once_due;

  wire [11:0] lmfc_target = {7'h00, frame_shift_q[`MSB_FRAME_SHIFT:0]} * FRAME_W;

  // Phase counter in half-rate ticks; a realigning pulse pulls it back to zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 12'h000;
    end else if (realign) begin
      phase_q <= 12'h000;
    end else if (half_tick) begin
      if (phase_q >= PERIOD_W - 12'h001) begin
        phase_q <= 12'h000;
      end else begin
        phase_q <= phase_q + 12'h001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_align <= 1'b0;
      nco_reset <= 1'b0;
      lmfc_pulse <= 1'b0;
    end else begin
      divider_align <= realign; // [RULE1]
      nco_reset <= nco_hit; // [RULE4] [RULE5]
      lmfc_pulse <= half_tick && (phase_q == lmfc_target); // [RULE7]
    end
  end

  // Remembers that the first pulse of a second-pulse alignment has passed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_first_q <= 1'b0;
    end else if (wr_sel || once_taken || !mode_once) begin
      seen_first_q <= 1'b0;
    end else if (sys_rise && mode_second) begin
      seen_first_q <= 1'b1; // [RULE3]
    end
  end

  // A software write landing with the self-clear keeps the written value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_sel_q <= `RST_ALIGN_SEL;
    end else if (wr_sel) begin
      align_sel_q <= pwdata[7:0];
    end else if (once_taken) begin
      align_sel_q[`BIT_ALIGN_ONCE] <= 1'b0; // [RULE2]
      align_sel_q[`BIT_NCO_ONCE] <= 1'b0; // [RULE5]
    end
  end

  // One process per register: a refused write never reaches any of them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_shift_q <= `RST_FRAME_SHIFT;
    end else if (wr_done && (slot == 4'h2)) begin
      frame_shift_q <= pwdata[7:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_win_q <= `RST_ALIGN_WIN;
    end else if (wr_done && (slot == 4'h3)) begin
      align_win_q <= pwdata[7:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_a_q <= `RST_LANE_A;
    end else if (wr_done && (slot == 4'h4)) begin
      lane_a_q <= pwdata[7:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_b_q <= `RST_LANE_B;
    end else if (wr_done && (slot == 4'h5)) begin
      lane_b_q <= pwdata[7:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emphasis_q <= `RST_EMPHASIS;
    end else if (wr_done && (slot == 4'h6)) begin
      emphasis_q <= pwdata[7:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_bias_q <= `RST_STBY_BIAS;
    end else if (wr_done && (slot == 4'h7)) begin
      stby_bias_q <= pwdata[7:0]; // [RULE13]
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_en_q <= `RST_SYNTH_EN;
    end else if (wr_done && (slot == 4'h8)) begin
      synth_en_q <= pwdata[7:0]; // [RULE12]
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_q <= `RST_DIV_LOW;
    end else if (wr_done && (slot == 4'h9)) begin
      div_low_q <= pwdata[7:0]; // [RULE11]
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_high_q <= `RST_DIV_HIGH;
    end else if (wr_done && (slot == 4'ha)) begin
      div_high_q <= pwdata[7:0]; // [RULE14]
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_q <= `RST_REF_DIV;
    end else if (wr_done && (slot == 4'hb)) begin
      ref_div_q <= pwdata[7:0];
    end
  end

  assign lane_polarity_invert = lane_a_q[`BIT_LANE_POL]; // [RULE10]
  assign external_clock_on = synth_en_q[7]; // [RULE12]
  assign converter_clock_on = synth_en_q[6];
  assign synthesizer_on = synth_en_q[5];
  assign oscillator_bias_on = synth_en_q[4];
  assign level_control_on = synth_en_q[3];
  assign oscillator_on = synth_en_q[2];
  assign calibration_override_on = synth_en_q[1];
  assign override_on = synth_en_q[0];
  assign synth_int_n = {div_high_q[`MSB_DIV_HIGH:0], div_low_q}; // [RULE11] [RULE14]
  assign standby_bias_code = stby_bias_q;
  assign ref_sample_clock_select = ref_div_q[`BIT_REF_SAMPLE_SEL];

endmodule

// ==== test/alignment_window_bank_chk.sv ====
// Purpose: Port checks of the ALIGNMENT_WINDOW alignment bank
// Assumes: One pclk domain, presetn asynchronous
// Notes: Bound after the module
`timescale 1ns/1ps
module alignment_window_bank_chk #(parameter FRAME_LEN = 4, parameter LMFC_FRAMES = 32) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire alignment_window_pin,
  input wire divider_align,
  input wire nco_reset,
  input wire lane_polarity_invert,
  input wire [10:0] synth_int_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] since_q;
  // Saturates so a stale pulse can never look recent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_q <= 4'hf;
    else if (alignment_window_pin)
      since_q <= 4'h0;
    else if (since_q != 4'hf)
      since_q <= since_q + 4'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_err_misalign: assert property (s_setup ##0 paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  a_nco_with_align:
    assert property (nco_reset |-> divider_align) else $error("nco reset without align");
  a_align_single:
    assert property (divider_align |=> !divider_align) else $error("align pulse too long");
  a_align_cause:
    assert property (divider_align |-> since_q <= 4'd12) else $error("align without alignment_window");
  a_div_low:
    assert property (s_commit(12'ha84) |=> synth_int_n[7:0] == $past(pwdata[7:0]))
    else $error("divider low byte not applied");
  a_div_high:
    assert property (s_commit(12'ha88) |=> synth_int_n[10:8] == $past(pwdata[2:0]))
    else $error("divider high bits not applied");
  a_lane_pol:
    assert property (s_commit(12'h7ac) |=> lane_polarity_invert == $past(pwdata[7]))
    else $error("lane polarity not applied");
endmodule

bind alignment_window_alignment_control_bank alignment_window_bank_chk #(.FRAME_LEN(FRAME_LEN),
  .LMFC_FRAMES(LMFC_FRAMES)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .alignment_window_pin, .divider_align, .nco_reset,
  .lane_polarity_invert, .synth_int_n);

// ==== test/alignment_window_source.sv ====
// Purpose: Timing source model giving ALIGNMENT_WINDOW pulses and a reference tick
// Assumes: fire is a one-cycle request from the bench
// Notes: Pulse held long enough for the slowest sampling tick
`timescale 1ns/1ps
module alignment_window_source #(parameter logic [3:0] HOLD = 4'h8) (
  input wire pclk,
  input wire presetn,
  input wire fire,
  output logic alignment_window_pin,
  output logic ref_tick
);
  logic [3:0] hold_q;
  logic [1:0] div_q;
  assign alignment_window_pin = hold_q != 4'h0;
  assign ref_tick = div_q == 2'h3;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 4'h0;
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (fire)
        hold_q <= HOLD;
      else if (hold_q != 4'h0)
        hold_q <= hold_q - 4'h1;
    end
  end
endmodule

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench of the ALIGNMENT_WINDOW alignment bank
// Assumes: One access cycle per APB transfer
// Notes: Random register data from an xorshift seeded at 29
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fire = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, alignment_window_pin, ref_tick, divider_align, nco_reset, lmfc_pulse, pol, sel;
  wire [7:0] en;
  wire [7:0] stby;
  wire [10:0] int_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_al = 0;
  int n_nco = 0;
  int t_al = 0;
  int t_lm = 0;
  logic [31:0] rnd = 32'h0000_001d;
  logic [31:0] rd;
  logic er;
  logic [11:0] adr [11] = '{12'h7a0, 12'h7a4, 12'h7a8, 12'h7ac, 12'h7b0, 12'h7bc, 12'h940,
    12'ha80, 12'ha84, 12'ha88, 12'haec};
  logic [7:0] rst [11] = '{8'h00, 8'h00, 8'h00, 8'h1c, 8'h00, 8'h00, 8'hff, 8'h00, 8'h80,
    8'h00, 8'hb9};
  logic [7:0] sh [11];
  alignment_window_alignment_control_bank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .alignment_window_pin, .ref_tick, .divider_align, .nco_reset,
    .lmfc_pulse, .lane_polarity_invert(pol), .external_clock_on(en[7]),
    .converter_clock_on(en[6]), .synthesizer_on(en[5]), .oscillator_bias_on(en[4]),
    .level_control_on(en[3]), .oscillator_on(en[2]), .calibration_override_on(en[1]),
    .override_on(en[0]), .synth_int_n(int_n), .standby_bias_code(stby),
    .ref_sample_clock_select(sel));
  alignment_window_source u_src (.pclk, .presetn, .fire, .alignment_window_pin, .ref_tick);
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (divider_align === 1'b1) n_al <= n_al + 1;
    if (divider_align === 1'b1) t_al <= cyc;
    if (nco_reset === 1'b1) n_nco <= n_nco + 1;
    if (lmfc_pulse === 1'b1) t_lm <= cyc;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts align and NCO pulses caused by one ALIGNMENT_WINDOW pulse
  task automatic pulse(input int ea, input int en_);
    int a0;
    int n0;
    a0 = n_al;
    n0 = n_nco;
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (16) @(posedge pclk);
    cmp(n_al - a0, ea);
    cmp(n_nco - n0, en_);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (adr[i]) begin
      apb(1'b0, adr[i], 32'h0000_0000);
      cmp(rd, {24'h0, rst[i]});
    end
    $display("Test reset done");
    repeat (3) begin
      foreach (adr[i]) begin
        rnd = xs(rnd);
        sh[i] = rnd[7:0];
        apb(1'b1, adr[i], {24'h0, sh[i]});
      end
      foreach (adr[i]) begin
        apb(1'b0, adr[i], 32'h0000_0000);
        cmp(rd, {24'h0, sh[i]});
      end
      cmp({pol, en, stby}, {sh[3][7], sh[7], sh[6]});
      cmp({int_n, sel}, {sh[9][2:0], sh[8], sh[10][3]});
    end
    apb(1'b1, 12'h940, 32'h0000_0095);
    @(posedge pclk);
    cmp(stby, 8'h95);
    apb(1'b0, 12'h004, 32'h0000_0000);
    cmp({31'h0, er}, 32'h0000_0001);
    cmp(rd, 32'h0000_0000);
    apb(1'b1, 12'h7a5, 32'h0000_001f);
    cmp({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 12'h7a4, 32'h0000_0000);
    cmp({er, rd[30:0]}, {1'b0, 23'h0, sh[1]});
    $display("Test registers done");
    apb(1'b1, 12'h7a8, 32'h0000_0000);
    apb(1'b1, 12'h7a4, 32'h0000_0005);
    apb(1'b1, 12'haec, 32'h0000_00b9);
    apb(1'b1, 12'h7a0, 32'h0000_0000);
    pulse(0, 0);
    apb(1'b1, 12'h7a0, 32'h0000_0011);
    pulse(1, 1);
    pulse(1, 1);
    apb(1'b1, 12'h7a0, 32'h0000_0022);
    pulse(1, 1);
    apb(1'b0, 12'h7a0, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    pulse(0, 0);
    apb(1'b1, 12'h7a0, 32'h0000_0066);
    pulse(0, 0);
    pulse(1, 1);
    apb(1'b0, 12'h7a0, 32'h0000_0000);
    cmp(rd, 32'h0000_0044);
    $display("Test modes done");
    apb(1'b1, 12'haec, 32'h0000_00b1);
    apb(1'b1, 12'h7a0, 32'h0000_0001);
    pulse(1, 0);
    apb(1'b1, 12'haec, 32'h0000_00b9);
    apb(1'b1, 12'h7a8, 32'h0000_000f);
    pulse(0, 0);
    apb(1'b1, 12'h7a8, 32'h0000_00f0);
    repeat (200) @(posedge pclk);
    pulse(0, 0);
    apb(1'b1, 12'h7a8, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    pulse(1, 0);
    repeat (40) @(posedge pclk);
    cmp((t_lm - t_al) >= 38 && (t_lm - t_al) <= 42, 32'h0000_0001);
    $display("Test window done");
    wrap_up();
  end
endmodule
